// [hdl/stamp_pkg.sv]
// shared widths, timing constants, states and carriers of the stamp block
`default_nettype none
package stamp_pkg;
  localparam int EV_W     = 24;   // raw event count width
  localparam int TM_W     = 32;   // raw coarse time width
  localparam int IN_W     = 16;   // interpolator/status word width
  localparam int TX_W     = 40;   // rollover-extended coarse time
  localparam int EX_W     = 32;   // rollover-extended event count
  localparam int ST_W     = 48;   // time stamp, units of the fine step
  localparam int FRAC_W   = 16;   // fraction bits of both quotients
  localparam int DIV_W    = 64;   // divider operand width
  localparam int COARSE_STEP_PS = 2000; // one coarse count, 2 ns
  localparam int FINE_STEP_PS   = 100;  // one interpolator count, 0.1 ns
  localparam int COARSE_PER_FINE = COARSE_STEP_PS / FINE_STEP_PS;
  localparam int CHAN_C_SHIFT   = 2;    // channel c counts one edge in four

  // one sample of a measurement pair
  typedef struct packed {
    logic [EV_W-1:0] ev;          // channel event count
    logic [TM_W-1:0] tm;          // coarse time of occurrence
    logic [IN_W-1:0] fine;        // interpolator datum
    logic            blk_first;   // first sample of a block
    logic            inhibit;     // sample taken while inhibited
  } sample_t;

  // one measurement as delivered, sorted by channel
  typedef struct packed {
    sample_t start;               // start channel sample
    sample_t stop;                // stop channel sample
    logic    chan_c;              // measured on the divided channel
  } pair_t;

  // finished result of one measurement
  typedef struct packed {
    logic [DIV_W-1:0]        freq;       // events per fine step, fixed point
    logic [DIV_W-1:0]        period;     // fine steps per event, fixed point
    logic [ST_W-1:0]         gate;       // absolute gate time, fine steps
    logic signed [ST_W-1:0]  ts_start;   // start time stamp
    logic signed [ST_W-1:0]  ts_stop;    // corrected stop time stamp
    logic [EX_W-1:0]         ev_start;   // start event stamp
    logic [EX_W-1:0]         ev_stop;    // stop event stamp
    logic                    stop_first; // stop sample came first
    logic                    div_zero;   // a quotient had a zero divisor
    logic                    blk_first;  // block start seen in the pair
    logic                    inhibit;    // inhibit seen in the pair
  } result_t;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_WRAP  = 7'b000_0010,
    S_PAIRS = 7'b000_0100,
    S_STAMP = 7'b000_1000,
    S_FREQ  = 7'b001_0000,
    S_PER   = 7'b010_0000,
    S_OUT   = 7'b100_0000
  } state_t;
endpackage : stamp_pkg
`default_nettype wire

// [hdl/div_unit.sv]
// unsigned restoring divider, one quotient bit per clock
`default_nettype none
module div_unit #(
  parameter int W = 64            // operand width
) (
  input  wire logic         core_clk,  // system clock
  input  wire logic         rst_b,     // synchronous reset, active low
  input  wire logic         go,        // start pulse, taken when idle
  input  wire logic [W-1:0] num,       // dividend
  input  wire logic [W-1:0] den,       // divisor
  output logic              busy,      // division in progress
  output logic              done,      // one-cycle pulse, quotient ready
  output logic [W-1:0]      quo        // quotient, all ones on zero divisor
);
  localparam int CW = $clog2(W + 1);

  logic [W:0]    rem_q, rem_d;        // partial remainder
  logic [W-1:0]  quo_q, quo_d;        // dividend shifting into quotient
  logic [W-1:0]  den_q, den_d;        // held divisor
  logic [CW-1:0] cnt_q, cnt_d;        // bits left
  logic          busy_q, busy_d;      // running
  logic          done_q, done_d;      // finish pulse
  logic [W:0]    trial;               // shifted remainder before subtract

  // one restoring step per cycle; a zero divisor simply yields all ones
  always_comb
  begin
    rem_d  = rem_q;
    quo_d  = quo_q;
    den_d  = den_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trial  = {rem_q[W-1:0], quo_q[W-1]};
    if (!busy_q && go)
    begin
      rem_d  = '0;
      quo_d  = num;
      den_d  = den;
      cnt_d  = CW'(W);
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (trial >= {1'b0, den_q})
      begin
        rem_d = trial - {1'b0, den_q};
        quo_d = {quo_q[W-2:0], 1'b1};
      end
      else
      begin
        rem_d = trial;
        quo_d = {quo_q[W-2:0], 1'b0};
      end
      cnt_d = cnt_q - CW'(1);
      if (cnt_q == CW'(1))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // register the step
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      den_q  <= den_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign quo  = quo_q;
endmodule : div_unit
`default_nettype wire

// [hdl/pair_stamp_proc.sv]
// host-side processor turning measurement pairs into rates and gate times
//
// What this block does
// - decide per pair which came first, by time
// - tell order reversals apart from counter wraps
// - time wraps fixed in two passes
// - too large difference: correct start and later data
// - too small difference: correct stop and later data
// - last pair's true stop above this pair's true start: correct both times of this pair and later data
// - stamp is coarse times 2 ns minus fine
// - add path offset to stop stamps only
// - later count smaller: correct only the later count
// - rate is event difference over time difference
// - expanded output gives absolute stop minus start
// - divided channel events multiplied by four
`default_nettype none
module pair_stamp_proc
  import stamp_pkg::*;
#(
  parameter logic signed [TX_W-1:0] TIME_OVF = 40'sh01_0000_0000,
  parameter logic signed [TX_W-1:0] TIME_MAX = 40'sh00_8000_0000,
  parameter logic [EX_W-1:0]        EVT_OVF  = 32'h0100_0000
) (
  input  wire logic                     core_clk,    // 20 MHz clock
  input  wire logic                     rst_b,       // sync reset, low
  input  wire stamp_pkg::pair_t         in_pair,     // measurement pair
  input  wire logic                     in_valid,    // pair offered
  output logic                          in_ready,    // pair accepted
  input  wire logic signed [stamp_pkg::ST_W-1:0] path_offset, // stop skew
  input  wire logic                     expanded_en, // report gate time
  output stamp_pkg::result_t            out_res,     // finished result
  output logic                          out_valid,   // result offered
  input  wire logic                     out_ready    // result taken
);
  import stamp_pkg::*;

  state_t                 state_q, state_d;     // sequencer
  pair_t                  pair_q, pair_d;       // held raw pair
  logic signed [TX_W-1:0] st_q, st_d;           // extended start time
  logic signed [TX_W-1:0] sp_q, sp_d;           // extended stop time
  logic signed [TX_W-1:0] acc1_q, acc1_d;       // first pass offset
  logic signed [TX_W-1:0] acc2_q, acc2_d;       // second pass offset
  logic signed [TX_W-1:0] prev_hi_q, prev_hi_d; // true stop of last pair
  logic                   have_prev_q, have_prev_d; // a pair was seen
  logic signed [EX_W-1:0] de_q, de_d;           // stop minus start events
  logic signed [ST_W-1:0] dt_q, dt_d;           // stop minus start time
  logic                   launched_q, launched_d; // divider started
  result_t                res_q, res_d;         // output result

  logic signed [TX_W-1:0] diff;       // stop minus start, first pass
  logic signed [TX_W-1:0] sa, pa;     // times after second pass offset
  logic signed [TX_W-1:0] lo, hi;     // true start and true stop
  logic                   wrap2;      // wrap between pairs
  logic                   stop_first; // stop came first
  logic [EX_W-1:0]        e_first, e_last; // events in collection order
  logic [EX_W-1:0]        e_start, e_stop; // events by channel
  logic signed [ST_W-1:0] t_start, t_stop; // time stamps
  logic [EX_W-1:0]        abs_de;     // magnitude of event difference
  logic [ST_W-1:0]        abs_dt;     // magnitude of time difference
  logic                   div_go;     // start the divider
  logic [DIV_W-1:0]       div_num;    // dividend
  logic [DIV_W-1:0]       div_den;    // divisor
  logic                   div_busy;   // divider running
  logic                   div_done;   // quotient ready
  logic [DIV_W-1:0]       div_quo;    // quotient

  // coarse count times 2 ns less fine count times 0.1 ns, in fine units
  function automatic logic signed [ST_W-1:0] to_stamp(
    input logic signed [TX_W-1:0] t,
    input logic [IN_W-1:0]        f
  );
    logic signed [ST_W-1:0] tw;
    tw = ST_W'(t);
    to_stamp = tw * ST_W'(COARSE_PER_FINE) - $signed(ST_W'(f));
  endfunction : to_stamp

  // both differences share a sign, so magnitudes give a positive quotient
  assign abs_de = de_q[EX_W-1] ? EX_W'(-de_q) : EX_W'(de_q);
  assign abs_dt = dt_q[ST_W-1] ? ST_W'(-dt_q) : ST_W'(dt_q);
  // start only once per state and only into an idle divider
  assign div_go = (state_q == S_FREQ || state_q == S_PER) && !launched_q
                  && !div_busy;
  // both quotients carry FRAC_W fraction bits, so shift by FRAC_W only
  assign div_num = (state_q == S_FREQ) ? DIV_W'({abs_de, {FRAC_W{1'b0}}})
                                       : DIV_W'({abs_dt, {FRAC_W{1'b0}}});
  assign div_den = (state_q == S_FREQ) ? DIV_W'(abs_dt) : DIV_W'(abs_de);

  // shared divider, used once for frequency and once for period
  div_unit #(
    .W        (DIV_W)
  ) u_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .go       (div_go),
    .num      (div_num),
    .den      (div_den),
    .busy     (div_busy),
    .done     (div_done),
    .quo      (div_quo)
  );

  assign in_ready  = (state_q == S_IDLE);
  assign out_valid = (state_q == S_OUT);
  assign out_res   = res_q;

  // sequencer: wrap passes, stamps, events, then two divisions
  always_comb
  begin
    state_d     = state_q;
    pair_d      = pair_q;
    st_d        = st_q;
    sp_d        = sp_q;
    acc1_d      = acc1_q;
    acc2_d      = acc2_q;
    prev_hi_d   = prev_hi_q;
    have_prev_d = have_prev_q;
    de_d        = de_q;
    dt_d        = dt_q;
    launched_d  = launched_q;
    res_d       = res_q;
    diff        = sp_q - st_q;
    sa          = st_q + acc2_q;
    pa          = sp_q + acc2_q;
    lo          = (sa < pa) ? sa : pa;
    wrap2       = have_prev_q && (prev_hi_q > lo);
    stop_first  = sp_q < st_q;
    e_first     = stop_first ? EX_W'(pair_q.stop.ev)
                             : EX_W'(pair_q.start.ev);
    e_last      = stop_first ? EX_W'(pair_q.start.ev)
                             : EX_W'(pair_q.stop.ev);
    // counts restart every pair, so only the pair itself is compared
    if (e_last < e_first)
      e_last = e_last + EVT_OVF;
    e_start     = stop_first ? e_last : e_first;
    e_stop      = stop_first ? e_first : e_last;
    if (pair_q.chan_c)
    begin
      e_start = e_start << CHAN_C_SHIFT;
      e_stop  = e_stop << CHAN_C_SHIFT;
    end
    t_start     = to_stamp(st_q, pair_q.start.fine);
    t_stop      = to_stamp(sp_q, pair_q.stop.fine) + path_offset;
    hi          = '0;
    unique case (state_q)
      S_IDLE:
      begin
        // no order is assumed: every pair is judged on its own times
        if (in_valid)
        begin
          pair_d  = in_pair;
          st_d    = TX_W'(in_pair.start.tm) + acc1_q;
          sp_d    = TX_W'(in_pair.stop.tm) + acc1_q;
          state_d = S_WRAP;
        end
      end
      S_WRAP:
      begin
        // a modest negative difference is a reversal and is left alone
        if (diff > TIME_MAX)
        begin
          st_d   = st_q + TIME_OVF;
          acc1_d = acc1_q + TIME_OVF;
        end
        else if (diff < -TIME_MAX)
        begin
          sp_d    = sp_q + TIME_OVF;
          acc1_d  = acc1_q + TIME_OVF;
          state_d = S_PAIRS;
        end
        else
          state_d = S_PAIRS;
      end
      S_PAIRS:
      begin
        // second pass: compare true start to the last pair's true stop
        if (wrap2)
        begin
          sa     = sa + TIME_OVF;
          pa     = pa + TIME_OVF;
          acc2_d = acc2_q + TIME_OVF;
        end
        hi          = (sa > pa) ? sa : pa;
        st_d        = sa;
        sp_d        = pa;
        prev_hi_d   = hi;
        have_prev_d = 1'b1;
        state_d     = S_STAMP;
      end
      S_STAMP:
      begin
        de_d  = $signed(e_stop - e_start);
        dt_d  = t_stop - t_start;
        res_d.ts_start   = t_start;
        res_d.ts_stop    = t_stop;
        res_d.ev_start   = e_start;
        res_d.ev_stop    = e_stop;
        res_d.stop_first = stop_first;
        res_d.blk_first  = pair_q.start.blk_first | pair_q.stop.blk_first;
        res_d.inhibit    = pair_q.start.inhibit | pair_q.stop.inhibit;
        res_d.div_zero   = 1'b0;
        state_d          = S_FREQ;
      end
      S_FREQ:
      begin
        if (div_go)
          launched_d = 1'b1;
        if (div_done)
        begin
          res_d.freq     = div_quo;
          res_d.div_zero = (abs_dt == '0);
          launched_d     = 1'b0;
          state_d        = S_PER;
        end
      end
      S_PER:
      begin
        if (div_go)
          launched_d = 1'b1;
        if (div_done)
        begin
          res_d.period   = div_quo;
          res_d.div_zero = res_q.div_zero | (abs_de == '0);
          // gate is only reported when expanded output is on
          res_d.gate     = expanded_en ? abs_dt : '0;
          launched_d     = 1'b0;
          state_d        = S_OUT;
        end
      end
      S_OUT:
      begin
        if (out_ready)
          state_d = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  // register the sequencer and its working values
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q     <= S_IDLE;
      pair_q      <= '0;
      st_q        <= '0;
      sp_q        <= '0;
      acc1_q      <= '0;
      acc2_q      <= '0;
      prev_hi_q   <= '0;
      have_prev_q <= 1'b0;
      de_q        <= '0;
      dt_q        <= '0;
      launched_q  <= 1'b0;
      res_q       <= '0;
    end
    else
    begin
      state_q     <= state_d;
      pair_q      <= pair_d;
      st_q        <= st_d;
      sp_q        <= sp_d;
      acc1_q      <= acc1_d;
      acc2_q      <= acc2_d;
      prev_hi_q   <= prev_hi_d;
      have_prev_q <= have_prev_d;
      de_q        <= de_d;
      dt_q        <= dt_d;
      launched_q  <= launched_d;
      res_q       <= res_d;
    end
  end
endmodule : pair_stamp_proc
`default_nettype wire

// [verif/instrument_model.sv]
// behavioural instrument offering measurement pairs to the block
`default_nettype none
module instrument_model
(
  input  wire logic        core_clk, // system clock
  input  wire logic        in_ready, // block takes the pair
  output stamp_pkg::pair_t in_pair,  // pair on offer
  output logic             in_valid  // pair offered
);
  timeunit 1ns;
  timeprecision 1ps;
  import stamp_pkg::*;

  pair_t pend_q[$]; // pairs not yet taken, in stream order
  pair_t last;      // last pair shown, kept for idle scrambling
  logic  took;      // pair taken at the last rising edge

  initial
  begin
    in_valid = 1'b0;
    in_pair  = '0;
    last     = '0;
    took     = 1'b0;
  end

  // the order inside each pair is picked per pair by the caller
  // counts arrive as freshly cleared counters give them
  task automatic push(input pair_t p);
    pend_q.push_back(p);
  endtask : push

  // note the handshake where the block samples it
  always @(posedge core_clk)
    took = in_valid && in_ready;

  // change the offer only away from the sampling edge
  always @(negedge core_clk)
  begin
    if (took)
      void'(pend_q.pop_front());
    if (pend_q.size() != 0)
    begin
      in_valid = 1'b1;
      in_pair  = pend_q[0]; // both samples travel together
      last     = pend_q[0];
    end
    else
    begin
      in_valid = 1'b0;
      in_pair  = ~last; // released lines must not repeat the old pair
    end
  end
endmodule : instrument_model
`default_nettype wire

// [verif/pair_stamp_proc_chk.sv]
// port checks of the pair stamp processor
`default_nettype none
module pair_stamp_proc_chk
(
  input wire logic                core_clk,    // system clock
  input wire logic                rst_b,       // sync reset, low
  input wire logic                in_valid,    // pair offered
  input wire logic                in_ready,    // pair accepted
  input wire logic                expanded_en, // gate time wanted
  input wire stamp_pkg::result_t  out_res,     // finished result
  input wire logic                out_valid,   // result offered
  input wire logic                out_ready    // result taken
);
  import stamp_pkg::*;
  logic [ST_W-1:0] span; // absolute stamp difference

  // magnitude of stop minus start, whichever came first
  always_comb
  begin
    if ($signed(out_res.ts_stop) < $signed(out_res.ts_start))
      span = out_res.ts_start - out_res.ts_stop;
    else
      span = out_res.ts_stop - out_res.ts_start;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_quiet;
    !out_valid [*8];
  endsequence
  sequence s_hand;
    out_valid && out_ready;
  endsequence

  property p_take_busy;
    s_take |=> !in_ready;
  endproperty
  property p_latency;
    s_take |=> s_quiet ##[90:400] out_valid;
  endproperty
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_res);
  endproperty
  property p_excl;
    in_ready |-> !out_valid;
  endproperty
  property p_release;
    s_hand |=> in_ready && !out_valid;
  endproperty
  property p_gate;
    out_valid |-> out_res.gate == (expanded_en ? span : '0);
  endproperty
  property p_ev_order;
    out_valid |-> (out_res.stop_first ? out_res.ev_start >= out_res.ev_stop
                                      : out_res.ev_stop >= out_res.ev_start);
  endproperty
  property p_zero_div;
    out_valid && out_res.ev_stop == out_res.ev_start
      |-> out_res.div_zero && (&out_res.period);
  endproperty

  a_take_busy: assert property (p_take_busy)
    else $error("pair taken but block still ready");
  a_latency: assert property (p_latency)
    else $error("result not offered within its window");
  a_hold: assert property (p_hold)
    else $error("result changed or dropped before taken");
  a_excl: assert property (p_excl)
    else $error("ready for a pair while a result waits");
  a_release: assert property (p_release)
    else $error("block not idle after result taken");
  a_gate: assert property (p_gate)
    else $error("gate time not absolute stamp difference");
  a_ev_order: assert property (p_ev_order)
    else $error("later event count below earlier count");
  a_zero_div: assert property (p_zero_div)
    else $error("zero event difference not flagged");
endmodule : pair_stamp_proc_chk

bind pair_stamp_proc pair_stamp_proc_chk pair_stamp_proc_chk_i (
  .core_clk    (core_clk),
  .rst_b       (rst_b),
  .in_valid    (in_valid),
  .in_ready    (in_ready),
  .expanded_en (expanded_en),
  .out_res     (out_res),
  .out_valid   (out_valid),
  .out_ready   (out_ready)
);
`default_nettype wire

// [verif/pair_stamp_proc_test.sv]
// self-checking bench for the pair stamp processor
`default_nettype none
module pair_stamp_proc_test;
  timeunit 1ns;
  timeprecision 1ps;
  import stamp_pkg::*;

  localparam longint TW = 64'h3e8; // raw time wraps at 1000 counts
  logic                   core_clk;    // 20 MHz clock
  logic                   rst_b;       // sync reset, low
  pair_t                  in_pair;     // pair from instrument
  logic                   in_valid;    // pair offered
  logic                   in_ready;    // pair accepted
  logic signed [ST_W-1:0] path_offset; // stop skew, fine units
  logic                   expanded_en; // gate time wanted
  result_t                out_res;     // finished result
  logic                   out_valid;   // result offered
  logic                   out_ready;   // result taken
  result_t                exp_q[$];    // expected results, oldest first
  int                     n_fail;      // mismatches
  int                     cmp_count;   // comparisons made
  logic [31:0]            rng;         // xorshift state
  longint                 t_now;       // true time of the last sample

  pair_stamp_proc #(
    .TIME_OVF (40'sh00_0000_03e8), // small wrap keeps runs short
    .TIME_MAX (40'sh00_0000_0064), // in-pair limit of 100
    .EVT_OVF  (32'h0000_0100)      // event wrap at 256
  ) pair_stamp_proc_i (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .in_pair     (in_pair),
    .in_valid    (in_valid),
    .in_ready    (in_ready),
    .path_offset (path_offset),
    .expanded_en (expanded_en),
    .out_res     (out_res),
    .out_valid   (out_valid),
    .out_ready   (out_ready)
  );
  instrument_model instrument_model_i (
    .core_clk (core_clk),
    .in_ready (in_ready),
    .in_pair  (in_pair),
    .in_valid (in_valid)
  );

  initial
    core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // xorshift step, then a value below n
  function automatic longint rnd(input longint n);
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return longint'(rng) % n;
  endfunction : rnd

  task automatic cmp_res(input result_t e, input result_t g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED out_res expected %h seen %h", e, g);
    end
  endtask : cmp_res

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if ((n_fail == 0) && (cmp_count > 0))
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // one pair from true times; expectation follows the true timeline
  task automatic gen(input longint gap, input longint span, input bit sf,
                     input longint e0, input longint n);
    pair_t   p;
    result_t r;
    longint  ta, tz, fa, fz, dt, k;
    p = '0;
    r = '0;
    p.chan_c = 1'(rnd(2));
    k = p.chan_c ? 4 : 1; // divided channel counts one in four
    ta = sf ? t_now + gap + span : t_now + gap;
    tz = sf ? t_now + gap : t_now + gap + span;
    t_now = t_now + gap + span;
    fa = rnd(10);
    fz = rnd(10);
    p.start.tm = 32'(ta % TW);
    p.stop.tm = 32'(tz % TW);
    p.start.fine = 16'(fa);
    p.stop.fine = 16'(fz);
    p.start.ev = 24'(sf ? (e0 + n) % 256 : e0);
    p.stop.ev = 24'(sf ? e0 : (e0 + n) % 256);
    p.start.blk_first = 1'(rnd(2));
    p.stop.inhibit = 1'(rnd(2));
    r.ts_start = 48'(ta * 20 - fa);
    r.ts_stop = 48'(tz * 20 - fz + longint'(path_offset));
    dt = (tz * 20 - fz + longint'(path_offset)) - (ta * 20 - fa);
    dt = (dt < 0) ? -dt : dt;
    r.ev_start = 32'((sf ? e0 + n : e0) * k);
    r.ev_stop = 32'((sf ? e0 : e0 + n) * k);
    r.freq = 64'(((n * k) << 16) / dt);
    r.period = (n == 0) ? '1 : 64'((dt << 16) / (n * k));
    r.div_zero = (n == 0);
    r.gate = expanded_en ? 48'(dt) : '0;
    r.stop_first = sf;
    r.blk_first = p.start.blk_first;
    r.inhibit = p.stop.inhibit;
    exp_q.push_back(r);
    instrument_model_i.push(p);
  endtask : gen

  task automatic rgen(input int cnt);
    repeat (cnt)
      gen(rnd(700) + 1, rnd(60) + 2, 1'(rnd(2)), rnd(256), rnd(40));
  endtask : rgen

  // wait, bounded, until every expected result was seen
  task automatic drain();
    int k;
    k = 0;
    while ((exp_q.size() != 0) && (k < 40000))
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 40000)
    begin
      n_fail++;
      $display("CHECK FAILED drain expected 0 seen %0d", exp_q.size());
      summarize();
    end
  endtask : drain

  // host side stalls at random so results must stand
  always @(negedge core_clk)
    out_ready = (rnd(4) != 0);

  // take the oldest note whenever a result is handed over
  always @(posedge core_clk)
  begin
    if (rst_b && out_valid && out_ready)
    begin
      if (exp_q.size() == 0)
        cmp_res('0, out_res);
      else
        cmp_res(exp_q.pop_front(), out_res);
    end
  end

  initial
  begin
    rst_b = 1'b0;
    out_ready = 1'b0;
    expanded_en = 1'b0;
    path_offset = 48'sh0000_0000_0005;
    rng = 32'hff278333;
    n_fail = 0;
    cmp_count = 0;
    t_now = 64'h3dd;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    gen(1, 15, 1'b1, 64'hfa, 10);
    gen(990, 10, 1'b0, 64'h07, 0);
    rgen(18);
    drain();
    $display("test reversed pairs and wraps, gate off: done");
    expanded_en = 1'b1;
    path_offset = 48'shffff_ffff_fff9;
    rgen(25);
    drain();
    $display("test gate on, negative offset: done");
    summarize();
  end
endmodule : pair_stamp_proc_test
`default_nettype wire
